//--- verilog/cps_map.svh
// register offsets, field positions, reset values and masks of the port status and configuration bank
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH

`define CPS_OFF_LEGACY_STATUS    8'h13
`define CPS_OFF_PIN_STATUS       8'h14
`define CPS_OFF_GENERAL_CFG      8'h15
`define CPS_OFF_EMULATION_CFG    8'h16
`define CPS_OFF_SWITCH_CFG       8'h17
`define CPS_OFF_ATTACH_CFG       8'h18
`define CPS_OFF_DATA_SWITCH_CFG  8'h25

`define CPS_RST_GENERAL_CFG      8'h01
`define CPS_RST_EMULATION_CFG    8'h8c
`define CPS_RST_SWITCH_CFG       8'h04
`define CPS_RST_ATTACH_CFG       8'h46
`define CPS_RST_DATA_SWITCH_CFG  8'h14

// writable bits; everything else reads zero
`define CPS_MASK_GENERAL_CFG     8'hbb
`define CPS_MASK_EMULATION_CFG   8'h9f
`define CPS_MASK_SWITCH_CFG      8'hbf
`define CPS_MASK_ATTACH_CFG      8'hff
`define CPS_MASK_DATA_SWITCH_CFG 8'hff

// legacy profile status
`define CPS_BIT_LEGACY_ONE       0
`define CPS_BIT_LEGACY_TWO       1

// general configuration
`define CPS_BIT_ALERT_MASK       7
`define CPS_BIT_ALERT_LINK       5
`define CPS_BIT_DISCHARGE        4
`define CPS_BIT_LIMIT_ENABLE     3
`define CPS_BIT_LIMIT_RESET      2
`define CPS_LSB_LIMIT_ACTION     0

// switch configuration
`define CPS_BIT_PIN_IGNORE       7
`define CPS_BIT_EMUL_EN_SW       5
`define CPS_BIT_MODE_B_SW        4
`define CPS_BIT_MODE_A_SW        3
`define CPS_BIT_POWER_EN_SW      1

// power state field encoding
`define CPS_PWR_SLEEP            2'h0
`define CPS_PWR_DETECT           2'h1
`define CPS_PWR_ACTIVE           2'h2
`define CPS_PWR_ERROR            2'h3

// charge limit action encoding
`define CPS_ACT_REPORT           2'h0
`define CPS_ACT_REPORT_DISC      2'h1
`define CPS_ACT_DISC_SLEEP       2'h2
`define CPS_ACT_IGNORE           2'h3

`endif

//--- verilog/cps_pkg.sv
// shared types of the port status and configuration bank
package cps_pkg;
  typedef logic [7:0] cps_byte_t;
  typedef logic [1:0] cps_pwr_t;
  typedef logic [1:0] cps_action_t;
endpackage

//--- verilog/cps_regs.sv
// port status and configuration register bank of the port power controller
// Operation
// - set legacy-two status bit on profile two handshake; data switch then follows charger bit
// - set legacy-one status bit on profile one handshake with same switch handling
// - pin status bits 6..3 mirror effective power, mode b, mode a, emulation enables
// - pin status bit 2 captures decoded enable polarity once after power-up
// - power state field tracks state: detect, active, error; a sleep code reads as detect
// - any register access wakes device; power state never reads as sleep
// - general configuration keeps contents across sleep
// - alert mask set blocks error alerts; clear lets errors and events alert
// - alert link routes low-current and thermal flags onto alert
// - discharge bit in active state opens switch and discharges, not self-clearing
// - limit disable zeroes accumulator, stops accumulating, removes response, clears status
// - limit reset write zeroes accumulator, clears status, releases alert if nothing remains
// - limit action field selects report, report-disconnect, disconnect-sleep or ignore
// - legacy status clears on power disable, new mode, or removal
// - legacy status bits never drive alert or attach-detect
// - each control is the OR of its pin (dropped while pin-ignore is set) and its software bit
`timescale 1ns/1ps
`include "cps_map.svh"

module cps_regs (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire cps_pkg::cps_byte_t reg_wdata,
  output logic      [7:0]        reg_rdata,
  input  wire logic              legacy_one_event,
  input  wire logic              legacy_two_event,
  input  wire logic              removal_event,
  input  wire logic              new_mode_event,
  input  wire logic              pin_port_power_enable,
  input  wire logic              pin_mode_select_a,
  input  wire logic              pin_mode_select_b,
  input  wire logic              pin_emulation_enable,
  input  wire logic              polarity_strap,
  input  wire cps_pkg::cps_pwr_t power_state_in,
  input  wire logic              error_active,
  input  wire logic              indicator_event,
  input  wire logic              low_current_flag,
  input  wire logic              thermal_regulation_flag,
  input  wire logic              charge_threshold_hit,
  output logic                   wake_request,
  output logic                   port_power_enable,
  output logic                   mode_select_a,
  output logic                   mode_select_b,
  output logic                   emulation_enable,
  output logic                   dedicated_charger_data_switch_ctl,
  output logic                   force_switch_open,
  output logic                   vbus_discharge_en,
  output logic                   charge_accum_clear,
  output logic                   charge_accum_enable,
  output logic                   charge_limit_status,
  output logic                   charge_limit_disconnect,
  output logic                   charge_limit_sleep,
  output logic                   alert_n,
  output logic      [7:0]        emulation_configuration,
  output logic      [7:0]        switch_configuration,
  output logic      [7:0]        attach_detect_configuration,
  output logic      [7:0]        data_switch_configuration
);

  logic [7:0] general_configuration;
  logic       legacy_one_accepted;
  logic       legacy_two_accepted;
  logic       polarity_high;
  logic       strap_taken;
  logic       alert_event_hold;

  // address decode
  wire sel_gen   = reg_addr == `CPS_OFF_GENERAL_CFG;
  wire sel_emu   = reg_addr == `CPS_OFF_EMULATION_CFG;
  wire sel_sw    = reg_addr == `CPS_OFF_SWITCH_CFG;
  wire sel_att   = reg_addr == `CPS_OFF_ATTACH_CFG;
  wire sel_dsw   = reg_addr == `CPS_OFF_DATA_SWITCH_CFG;
  wire wr_gen    = reg_wr && sel_gen;
  wire any_access = reg_wr || reg_rd;

  // fields of the general configuration
  wire                  alert_mask         = general_configuration[`CPS_BIT_ALERT_MASK];
  wire                  alert_link         = general_configuration[`CPS_BIT_ALERT_LINK];
  wire                  force_vbus_discharge = general_configuration[`CPS_BIT_DISCHARGE];
  wire                  charge_limit_enable = general_configuration[`CPS_BIT_LIMIT_ENABLE];
  wire cps_pkg::cps_action_t charge_limit_action =
    general_configuration[`CPS_LSB_LIMIT_ACTION +: 2];
  // reset is a write strobe, never stored
  wire charge_limit_reset = wr_gen && reg_wdata[`CPS_BIT_LIMIT_RESET];

  // effective controls: pins gated by pin ignore, power pin normalised by the strap polarity, ORed with software bit
  wire pin_ignore          = switch_configuration[`CPS_BIT_PIN_IGNORE];
  wire pin_power_active    = polarity_high ? pin_port_power_enable : !pin_port_power_enable;
  wire port_power_enable_sw = switch_configuration[`CPS_BIT_POWER_EN_SW];
  wire mode_select_a_sw    = switch_configuration[`CPS_BIT_MODE_A_SW];
  wire mode_select_b_sw    = switch_configuration[`CPS_BIT_MODE_B_SW];
  wire emulation_enable_sw = switch_configuration[`CPS_BIT_EMUL_EN_SW];
  wire power_enable_mirror     = (pin_power_active && !pin_ignore) || port_power_enable_sw;
  wire mode_a_mirror           = (pin_mode_select_a && !pin_ignore) || mode_select_a_sw;
  wire mode_b_mirror           = (pin_mode_select_b && !pin_ignore) || mode_select_b_sw;
  wire emulation_enable_mirror = (pin_emulation_enable && !pin_ignore) || emulation_enable_sw;

  // the access itself wakes the part, so a sleep code is shown as detect
  wire cps_pkg::cps_pwr_t power_state_field =
    (power_state_in == `CPS_PWR_SLEEP) ? `CPS_PWR_DETECT : power_state_in;

  wire [7:0] legacy_profile_status = {6'h00, legacy_two_accepted, legacy_one_accepted};
  wire [7:0] pin_and_power_state_status = {1'b0, power_enable_mirror, mode_b_mirror, mode_a_mirror,
                                           emulation_enable_mirror, polarity_high, power_state_field};

  wire [7:0] read_mux =
    (reg_addr == `CPS_OFF_LEGACY_STATUS) ? legacy_profile_status :
    (reg_addr == `CPS_OFF_PIN_STATUS)    ? pin_and_power_state_status :
    sel_gen ? general_configuration :
    sel_emu ? emulation_configuration :
    sel_sw  ? switch_configuration :
    sel_att ? attach_detect_configuration :
    sel_dsw ? data_switch_configuration : 8'h00;

  // legacy status clear conditions; a handshake in the same cycle wins
  wire legacy_clear = !power_enable_mirror || new_mode_event || removal_event;
  wire next_legacy_one = legacy_one_event || (legacy_one_accepted && !legacy_clear);
  wire next_legacy_two = legacy_two_event || (legacy_two_accepted && !legacy_clear);

  // charge limit status: disable clears outright, a reset strobe loses to a new hit
  wire limit_hit = charge_limit_enable && charge_threshold_hit && (charge_limit_action != `CPS_ACT_IGNORE);
  wire next_limit_status = charge_limit_enable &&
                           (limit_hit || (charge_limit_status && !charge_limit_reset));

  // alert: errors and ration report under the mask, flags through the link; legacy bits never enter
  wire report_alert = charge_limit_status && (charge_limit_action != `CPS_ACT_DISC_SLEEP);
  wire error_alert  = !alert_mask && (error_active || alert_event_hold || report_alert);
  wire flag_alert   = alert_link && (low_current_flag || thermal_regulation_flag);
  wire next_alert_n = !(error_alert || flag_alert);

  // strap polarity caught on the first clock after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      polarity_high <= 1'b0;
      strap_taken   <= 1'b0;
    end else if (!strap_taken) begin
      polarity_high <= polarity_strap;
      strap_taken   <= 1'b1;
    end
  end

  // only power-on reset touches the configuration; sleep has no reset path here
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      general_configuration <= `CPS_RST_GENERAL_CFG;
    end else if (wr_gen) begin
      general_configuration <= reg_wdata & `CPS_MASK_GENERAL_CFG & ~(8'h01 << `CPS_BIT_LIMIT_RESET);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      emulation_configuration     <= `CPS_RST_EMULATION_CFG;
      switch_configuration        <= `CPS_RST_SWITCH_CFG;
      attach_detect_configuration <= `CPS_RST_ATTACH_CFG;
      data_switch_configuration   <= `CPS_RST_DATA_SWITCH_CFG;
    end else if (reg_wr) begin
      if (sel_emu) emulation_configuration     <= reg_wdata & `CPS_MASK_EMULATION_CFG;
      if (sel_sw)  switch_configuration        <= reg_wdata & `CPS_MASK_SWITCH_CFG;
      if (sel_att) attach_detect_configuration <= reg_wdata & `CPS_MASK_ATTACH_CFG;
      if (sel_dsw) data_switch_configuration   <= reg_wdata & `CPS_MASK_DATA_SWITCH_CFG;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      legacy_one_accepted <= 1'b0;
      legacy_two_accepted <= 1'b0;
      charge_limit_status <= 1'b0;
      alert_event_hold    <= 1'b0;
    end else begin
      legacy_one_accepted <= next_legacy_one;
      legacy_two_accepted <= next_legacy_two;
      charge_limit_status <= next_limit_status;
      // a one-cycle indicator event holds alert until a limit reset strobe
      alert_event_hold    <= indicator_event || (alert_event_hold && !charge_limit_reset);
    end
  end

  // read data captured once per read strobe so it cannot change mid-transfer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_request                      <= 1'b0;
      port_power_enable                 <= 1'b0;
      mode_select_a                     <= 1'b0;
      mode_select_b                     <= 1'b0;
      emulation_enable                  <= 1'b0;
      dedicated_charger_data_switch_ctl <= 1'b0;
      force_switch_open                 <= 1'b0;
      vbus_discharge_en                 <= 1'b0;
      charge_accum_clear                <= 1'b1;
      charge_accum_enable               <= 1'b0;
      charge_limit_disconnect           <= 1'b0;
      charge_limit_sleep                <= 1'b0;
      alert_n                           <= 1'b1;
    end else begin
      wake_request      <= any_access;
      port_power_enable <= power_enable_mirror;
      mode_select_a     <= mode_a_mirror;
      mode_select_b     <= mode_b_mirror;
      emulation_enable  <= emulation_enable_mirror;
      // tells the data switch to follow its dedicated-charger bit
      dedicated_charger_data_switch_ctl <= next_legacy_one || next_legacy_two;
      force_switch_open <= force_vbus_discharge && (power_state_in == `CPS_PWR_ACTIVE);
      vbus_discharge_en <= force_vbus_discharge && (power_state_in == `CPS_PWR_ACTIVE);
      charge_accum_clear  <= !charge_limit_enable || charge_limit_reset;
      charge_accum_enable <= charge_limit_enable;
      charge_limit_disconnect <= next_limit_status &&
        ((charge_limit_action == `CPS_ACT_REPORT_DISC) || (charge_limit_action == `CPS_ACT_DISC_SLEEP));
      charge_limit_sleep <= next_limit_status && (charge_limit_action == `CPS_ACT_DISC_SLEEP);
      alert_n <= next_alert_n;
    end
  end

  a_legacy_two_set: assert property (@(posedge clk) disable iff (!resetn)
    legacy_two_event |=> legacy_two_accepted) else $error("legacy two status not set");
  a_legacy_one_set: assert property (@(posedge clk) disable iff (!resetn)
    legacy_one_event |=> legacy_profile_status[0]) else $error("legacy one status not set");
  a_mirror_power: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd && reg_addr == `CPS_OFF_PIN_STATUS |=> reg_rdata[6] == $past(power_enable_mirror))
    else $error("power enable mirror wrong");
  a_pin_or_bit: assert property (@(posedge clk) disable iff (!resetn)
    mode_select_a_sw |=> mode_select_a) else $error("software mode bit not effective");
  a_never_sleep: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd |=> reg_rdata[1:0] != `CPS_PWR_SLEEP || $past(reg_addr) != `CPS_OFF_PIN_STATUS)
    else $error("power state read as sleep");
  a_mask_blocks: assert property (@(posedge clk) disable iff (!resetn)
    alert_mask && !alert_link |=> alert_n) else $error("alert asserted while masked");
  a_link_alert: assert property (@(posedge clk) disable iff (!resetn)
    alert_link && thermal_regulation_flag |=> !alert_n) else $error("linked flag did not alert");
  a_discharge_hold: assert property (@(posedge clk) disable iff (!resetn)
    force_vbus_discharge && power_state_in == `CPS_PWR_ACTIVE |=> force_switch_open && vbus_discharge_en)
    else $error("discharge did not open switch");
  a_disable_clears: assert property (@(posedge clk) disable iff (!resetn)
    !charge_limit_enable |=> !charge_limit_status && charge_accum_clear) else $error("disable did not clear");
  a_reset_clears: assert property (@(posedge clk) disable iff (!resetn)
    charge_limit_reset && !limit_hit |=> !charge_limit_status ##0 charge_accum_clear)
    else $error("limit reset did not clear");
  a_removal_clears: assert property (@(posedge clk) disable iff (!resetn)
    removal_event && !legacy_two_event |=> !legacy_two_accepted) else $error("removal left status set");
  a_reset_no_store: assert property (@(posedge clk) disable iff (!resetn)
    wr_gen |=> !general_configuration[`CPS_BIT_LIMIT_RESET] && !general_configuration[6])
    else $error("unimplemented bit stored");

  // read path, wake, retention, legacy clear, pin ignore, discharge and limit action guards
  a_polarity_held: assert property (@(posedge clk) disable iff (!resetn)
    strap_taken |=> $stable(polarity_high))
    else $error("strap polarity changed after capture");
  a_state_shown: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd && reg_addr == `CPS_OFF_PIN_STATUS && power_state_in != `CPS_PWR_SLEEP
    |=> reg_rdata[1:0] == $past(power_state_in)) else $error("power state field wrong");
  a_access_wakes: assert property (@(posedge clk) disable iff (!resetn)
    any_access |=> wake_request)
    else $error("access did not request wake");
  a_config_kept: assert property (@(posedge clk) disable iff (!resetn)
    !wr_gen |=> $stable(general_configuration))
    else $error("general configuration changed without a write");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd && !sel_gen && !sel_emu && !sel_sw && !sel_att && !sel_dsw && reg_addr != `CPS_OFF_LEGACY_STATUS
    && reg_addr != `CPS_OFF_PIN_STATUS |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_held: assert property (@(posedge clk) disable iff (!resetn)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_charger_switch: assert property (@(posedge clk) disable iff (!resetn)
    legacy_two_event |=> dedicated_charger_data_switch_ctl)
    else $error("data switch control not raised");
  a_mode_clears: assert property (@(posedge clk) disable iff (!resetn)
    new_mode_event && !legacy_one_event |=> !legacy_one_accepted)
    else $error("new mode left status set");
  a_power_off_clears: assert property (@(posedge clk) disable iff (!resetn)
    !power_enable_mirror && !legacy_two_event |=> !legacy_two_accepted)
    else $error("power disable left status set");
  a_mirror_modes: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd && reg_addr == `CPS_OFF_PIN_STATUS
    |=> reg_rdata[5:3] == $past({mode_b_mirror, mode_a_mirror, emulation_enable_mirror})) else $error("mode mirror wrong");
  a_action_disconnect: assert property (@(posedge clk) disable iff (!resetn)
    charge_limit_enable && charge_threshold_hit && charge_limit_action == `CPS_ACT_REPORT_DISC
    |=> charge_limit_status && charge_limit_disconnect && !charge_limit_sleep) else $error("report disconnect wrong");
  a_ignore_quiet: assert property (@(posedge clk) disable iff (!resetn)
    charge_limit_action == `CPS_ACT_IGNORE && !charge_limit_status |=> !charge_limit_status)
    else $error("ignore action set status");
  a_accum_running: assert property (@(posedge clk) disable iff (!resetn)
    charge_limit_enable && !charge_limit_reset |=> charge_accum_enable && !charge_accum_clear)
    else $error("accumulator not running while enabled");
  a_pins_ignored: assert property (@(posedge clk) disable iff (!resetn)
    pin_ignore && !mode_select_a_sw |=> !mode_select_a)
    else $error("ignored pin still effective");
  a_discharge_idle: assert property (@(posedge clk) disable iff (!resetn)
    power_state_in != `CPS_PWR_ACTIVE |=> !force_switch_open && !vbus_discharge_en)
    else $error("discharge outside active state");

endmodule // cps_regs

//--- test/cps_host_model.sv
// host model issuing single-byte strobed register accesses
`timescale 1ns/1ps
module cps_host_model (
  input  wire logic              clk,
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic      [7:0]        reg_addr,
  output cps_pkg::cps_byte_t     reg_wdata,
  input  wire logic [7:0]        reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // idle address and data are inverted so a stale value is never mistaken for a valid one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule // cps_host_model

//--- test/cps_regs_tb_top.sv
// self-checking testbench of the port status and configuration bank
`timescale 1ns/1ps
`include "cps_map.svh"
module cps_regs_tb_top;
  logic clk = 1'b0, resetn = 1'b0, reg_wr, reg_rd, strap = 1'b1;
  logic [7:0] reg_addr, reg_rdata, emc, swc, adc, dsc;
  cps_pkg::cps_byte_t reg_wdata;
  logic [4:0] ev = 5'h00;
  logic pe = 1'b1, ma = 1'b0, mb = 1'b0, em = 1'b0, err = 1'b0, low = 1'b0, thr = 1'b0, hit = 1'b0;
  cps_pkg::cps_pwr_t ps = `CPS_PWR_DETECT;
  logic wake, o_pe, o_ma, o_mb, o_em, dcs, fso, vde, acl, aen, lst, ldc, lsl, alert_n;
  logic [7:0] rv;
  int failures = 0, checks_done = 0;
  logic [7:0] cfg_off [5] = '{`CPS_OFF_GENERAL_CFG, `CPS_OFF_EMULATION_CFG, `CPS_OFF_SWITCH_CFG,
                             `CPS_OFF_ATTACH_CFG, `CPS_OFF_DATA_SWITCH_CFG};
  logic [7:0] cfg_rst [5] = '{`CPS_RST_GENERAL_CFG, `CPS_RST_EMULATION_CFG, `CPS_RST_SWITCH_CFG,
                             `CPS_RST_ATTACH_CFG, `CPS_RST_DATA_SWITCH_CFG};

  cps_host_model u_cps_host_model (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  cps_regs u_cps_regs (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .legacy_one_event(ev[0]), .legacy_two_event(ev[1]),
    .removal_event(ev[2]), .new_mode_event(ev[3]), .indicator_event(ev[4]), .pin_port_power_enable(pe),
    .pin_mode_select_a(ma), .pin_mode_select_b(mb), .pin_emulation_enable(em), .polarity_strap(strap),
    .power_state_in(ps), .error_active(err), .low_current_flag(low), .thermal_regulation_flag(thr),
    .charge_threshold_hit(hit), .wake_request(wake), .port_power_enable(o_pe), .mode_select_a(o_ma),
    .mode_select_b(o_mb), .emulation_enable(o_em), .dedicated_charger_data_switch_ctl(dcs),
    .force_switch_open(fso), .vbus_discharge_en(vde), .charge_accum_clear(acl), .charge_accum_enable(aen),
    .charge_limit_status(lst), .charge_limit_disconnect(ldc), .charge_limit_sleep(lsl), .alert_n(alert_n),
    .emulation_configuration(emc), .switch_configuration(swc), .attach_detect_configuration(adc),
    .data_switch_configuration(dsc));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    u_cps_host_model.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_cps_host_model.wr(a, d);
  endtask
  // outputs are up to two registers deep, three edges leave margin
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 5'h00;
    settle();
  endtask
  task automatic final_report;
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #20000;
    failures++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, wake}, 8'h00);
    for (int i = 0; i < 5; i++) rdc(cfg_off[i], cfg_rst[i]);
    wr(`CPS_OFF_EMULATION_CFG, 8'hff);
    #1;
    chk({7'h00, wake}, 8'h01);
    chk(emc, `CPS_MASK_EMULATION_CFG);
    wr(`CPS_OFF_ATTACH_CFG, 8'h5a);
    wr(`CPS_OFF_DATA_SWITCH_CFG, 8'ha5);
    #1;
    chk(adc, 8'h5a);
    chk(dsc, 8'ha5);
    wr(`CPS_OFF_GENERAL_CFG, 8'hff);
    rdc(`CPS_OFF_GENERAL_CFG, 8'hbb);
    wr(`CPS_OFF_GENERAL_CFG, 8'h01);
    wr(`CPS_OFF_LEGACY_STATUS, 8'hff);
    rdc(`CPS_OFF_LEGACY_STATUS, 8'h00);
    rdc(8'h30, 8'h00);
    pulse(1);
    chk({6'h00, dcs, alert_n}, 8'h03);
    rdc(`CPS_OFF_LEGACY_STATUS, 8'h02);
    pulse(2);
    rdc(`CPS_OFF_LEGACY_STATUS, 8'h00);
    pulse(0);
    rdc(`CPS_OFF_LEGACY_STATUS, 8'h01);
    pulse(3);
    rdc(`CPS_OFF_LEGACY_STATUS, 8'h00);
    pulse(0);
    @(posedge clk);
    pe <= 1'b0;
    settle();
    rdc(`CPS_OFF_LEGACY_STATUS, 8'h00);
    @(posedge clk);
    ma <= 1'b1;
    settle();
    rdc(`CPS_OFF_PIN_STATUS, 8'h15);
    wr(`CPS_OFF_SWITCH_CFG, 8'h84);
    settle();
    chk({7'h00, o_ma}, 8'h00);
    rdc(`CPS_OFF_PIN_STATUS, 8'h05);
    @(posedge clk);
    ma <= 1'b0;
    wr(`CPS_OFF_SWITCH_CFG, 8'h3a);
    settle();
    chk({4'h0, o_pe, o_ma, o_mb, o_em}, 8'h0f);
    chk(swc, 8'h3a);
    rdc(`CPS_OFF_PIN_STATUS, 8'h7d);
    wr(`CPS_OFF_SWITCH_CFG, 8'h04);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      ps <= s[1:0];
      settle();
      rdc(`CPS_OFF_PIN_STATUS, (s == 0) ? 8'h05 : 8'h04 | s[7:0]);
    end
    @(posedge clk);
    ps <= `CPS_PWR_ACTIVE;
    wr(`CPS_OFF_GENERAL_CFG, 8'h11);
    settle();
    chk({6'h00, fso, vde}, 8'h03);
    @(posedge clk);
    ps <= `CPS_PWR_SLEEP;
    settle();
    rdc(`CPS_OFF_GENERAL_CFG, 8'h11);
    wr(`CPS_OFF_GENERAL_CFG, 8'h01);
    @(posedge clk);
    err <= 1'b1;
    settle();
    chk({7'h00, alert_n}, 8'h00);
    wr(`CPS_OFF_GENERAL_CFG, 8'h81);
    settle();
    chk({7'h00, alert_n}, 8'h01);
    @(posedge clk);
    low <= 1'b1;
    wr(`CPS_OFF_GENERAL_CFG, 8'ha1);
    settle();
    chk({7'h00, alert_n}, 8'h00);
    @(posedge clk);
    err <= 1'b0;
    low <= 1'b0;
    thr <= 1'b1;
    settle();
    chk({7'h00, alert_n}, 8'h00);
    wr(`CPS_OFF_GENERAL_CFG, 8'h81);
    settle();
    chk({7'h00, alert_n}, 8'h01);
    @(posedge clk);
    thr <= 1'b0;
    wr(`CPS_OFF_GENERAL_CFG, 8'h01);
    pulse(4);
    chk({7'h00, alert_n}, 8'h00);
    wr(`CPS_OFF_GENERAL_CFG, 8'h05);
    settle();
    chk({7'h00, alert_n}, 8'h01);
    @(posedge clk);
    hit <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      wr(`CPS_OFF_GENERAL_CFG, 8'h08 | a[7:0]);
      settle();
      chk({3'h0, aen, lst, ldc, lsl, alert_n}, {4'h1, a != 3, a == 1 || a == 2, a == 2, a >= 2});
      wr(`CPS_OFF_GENERAL_CFG, a[7:0]);
      settle();
      chk({3'h0, acl, lst, ldc, lsl, alert_n}, 8'h11);
    end
    wr(`CPS_OFF_GENERAL_CFG, 8'h08);
    @(posedge clk);
    hit <= 1'b0;
    settle();
    chk({6'h00, lst, alert_n}, 8'h02);
    wr(`CPS_OFF_GENERAL_CFG, 8'h0c);
    #1;
    chk({7'h00, acl}, 8'h01);
    settle();
    chk({6'h00, lst, alert_n}, 8'h01);
    @(posedge clk);
    strap <= 1'b0;
    settle();
    rdc(`CPS_OFF_PIN_STATUS, 8'h05);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(`CPS_OFF_PIN_STATUS, 8'h41);
    rdc(`CPS_OFF_GENERAL_CFG, `CPS_RST_GENERAL_CFG);
    final_report();
  end
endmodule // cps_regs_tb_top
